// file: logic/bwcg_core.sv
// block-write cycle generator: turns colour, mask and destination into memory cycles
// assumes the transfer engine holds parameters stable while START or RESUME is high
//
// How it works
// - 8x mode, one mask bit per line
// - 8x cycles cover aligned 64-byte regions
// - unaligned 8x destination refused with an error
// - little-endian 8x uses stride-eight lines from zero
// - big-endian 8x uses stride-eight lines from 63
// - 4x mode, each mask bit drives two lines
// - 4x cycles cover aligned 32-byte regions
// - 4x destination not 64-byte aligned refused with an error
// - little-endian 4x uses line pairs n, n+4
// - big-endian 4x uses line pairs 63-n, 59-n
// - 8-bit colour registers get the same pattern
// - emulated writes put full colour on bus
// - emulated mask bits become byte strobes
// - emulated writes are ordinary 64-bit writes
// - load colour register before 4x/8x cycles
// - colour load on start and on resume
// - no colour load in emulated mode
// - two-bit per-bank type selects the operation
// - block write needs long form, mode 010
// - error on on-chip or unaligned destination
`timescale 1ns/1ps
`default_nettype none
`include "bwcg_defs.svh"
module bwcg_core (
  input wire logic REF_CLK, // controller clock, 200 MHz
  input wire logic RST_N, // asynchronous reset, active low
  input wire logic START, // pulse: new transfer begins
  input wire logic RESUME, // pulse: transfer resumes after suspend or host request
  input wire logic SUSPEND, // pulse: stop issuing cycles, keep progress
  input wire logic BANK_SGRAM, // bank is SGRAM rather than VRAM
  input wire bwcg_pkg::bwcg_param_t PARAM, // transfer parameters
  input wire logic CYCLE_READY, // memory sequencer takes the cycle
  output logic CYCLE_VALID, // a cycle is offered
  output bwcg_pkg::bwcg_cycle_t CYCLE, // the offered cycle
  output logic BUSY, // transfer in progress
  output logic DONE, // pulse: transfer finished
  output logic XFER_ERROR // pulse: transfer refused
);

  ////////////////////////////////////////////////////////////////////////////
  // mask remap tables: two generate loops build both modes, both endians
  bwcg_pkg::bwcg_regs_t q_r;
  bwcg_pkg::bwcg_regs_t q_nxt;
  logic [63:0] map8_le;
  logic [63:0] map8_be;
  logic [63:0] map4_le;
  logic [63:0] map4_be;
  logic [63:0] src8;
  logic [31:0] src4;

  assign src8 = q_r.mask[63:0];
  assign src4 = q_r.mask[31:0];

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_map8
      // mask bit g lands on line 8*(g%8)+g/8 for little endian, on 63 minus that line for big endian
      assign map8_le[8 * (g % 8) + g / 8] = src8[g];
      assign map8_be[63 - (8 * (g % 8) + g / 8)] = src8[g];
    end
    for (g = 0; g < 32; g = g + 1) begin : g_map4
      // mask bit g drives a nibble pair
      assign map4_le[8 * (g % 8) + g / 8] = src4[g];
      assign map4_le[8 * (g % 8) + g / 8 + 4] = src4[g];
      assign map4_be[63 - (8 * (g % 8) + g / 8)] = src4[g];
      assign map4_be[59 - (8 * (g % 8) + g / 8)] = src4[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic [6:0] step;
  logic [5:0] offs;
  logic [7:0] used;
  logic [127:0] next_mask;
  logic [31:0] next_addr;
  logic bad;
  logic mode_ok;
  logic [127:0] shifted;
  logic [5:0] ent_offs;

  // bytes covered per cycle and the in-region offset of the current address
  always_comb begin
    step = `BWCG_STEP_SIM;
    offs = 6'h00;
    unique case (q_r.bw_type)
      `BWCG_BW_8X: begin
        step = `BWCG_STEP_8X;
        offs = {3'h0, q_r.addr[5:3]};
      end
      `BWCG_BW_4X: begin
        step = `BWCG_STEP_4X;
        offs = {4'h0, q_r.addr[4:3]};
      end
      default: begin
        step = `BWCG_STEP_SIM;
        offs = 6'h00;
      end
    endcase
    // a partial region consumes only the bits above its offset
    used = {1'b0, step} - {offs[4:0], 3'h0};
    next_mask = q_r.mask >> used;
    next_addr = q_r.addr + {24'h0, used};
  end

  ////////////////////////////////////////////////////////////////////////////
  // start checks on the offered parameters
  always_comb begin
    mode_ok = (PARAM.access_mode_select == `BWCG_PAM_BLOCK_WRITE) &&
              PARAM.long_form;
    bad = (PARAM.dst_addr <= `BWCG_ONCHIP_TOP) ||
          (PARAM.dst_addr[5:0] != 6'h00) ||
          (PARAM.block_write_type == `BWCG_BW_RSV);
  end

  ////////////////////////////////////////////////////////////////////////////
  // unaligned start: the mask is pre-shifted by the in-region offset on entry
  always_comb begin
    ent_offs = 6'h00;
    if (PARAM.block_write_type == `BWCG_BW_8X) begin
      ent_offs = {3'h0, PARAM.dst_addr[5:3]};
    end else if (PARAM.block_write_type == `BWCG_BW_4X) begin
      ent_offs = {4'h0, PARAM.dst_addr[4:3]};
    end else begin
      ent_offs = 6'h00;
    end
    // zeros fill the region locations below the first written one
    shifted = {112'h0, PARAM.mask_bits} << {ent_offs, 3'h0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // state sequencing and cycle construction
  always_comb begin
    q_nxt = q_r;
    q_nxt.err = 1'b0;
    q_nxt.done = 1'b0;
    unique case (q_r.state)
      bwcg_pkg::BWCG_IDLE: begin
        if (START) begin
          if (!mode_ok || bad) begin
            q_nxt.err = 1'b1;
          end else begin
            q_nxt.bw_type = PARAM.block_write_type;
            q_nxt.big_endian = PARAM.big_endian;
            q_nxt.is_sgram = BANK_SGRAM;
            q_nxt.colour = PARAM.colour;
            q_nxt.addr = PARAM.dst_addr;
            q_nxt.mask = shifted;
            q_nxt.mask_left = 8'h10;
            q_nxt.skip = 6'h00;
            if (PARAM.block_write_type == `BWCG_BW_SIM) begin
              q_nxt.state = bwcg_pkg::BWCG_WRITE;
            end else begin
              q_nxt.state = bwcg_pkg::BWCG_LOAD;
            end
          end
        end else if (RESUME && q_r.mask_left != 8'h00) begin
          // resume after suspend or host request reloads the colour register for 4x/8x types
          if (q_r.bw_type == `BWCG_BW_SIM) begin
            q_nxt.state = bwcg_pkg::BWCG_WRITE;
          end else begin
            q_nxt.state = bwcg_pkg::BWCG_LOAD;
          end
        end
      end
      bwcg_pkg::BWCG_LOAD: begin
        if (SUSPEND) begin
          q_nxt.state = bwcg_pkg::BWCG_IDLE;
        end else if (CYCLE_READY) begin
          q_nxt.state = bwcg_pkg::BWCG_WRITE;
        end
      end
      bwcg_pkg::BWCG_WRITE: begin
        if (SUSPEND) begin
          q_nxt.state = bwcg_pkg::BWCG_IDLE;
        end else if (CYCLE_READY) begin
          q_nxt.mask = next_mask;
          if (q_r.mask_left <= used) begin
            q_nxt.mask_left = 8'h00;
            q_nxt.state = bwcg_pkg::BWCG_DONE;
          end else begin
            q_nxt.mask_left = q_r.mask_left - used;
          end
          q_nxt.addr = next_addr;
        end
      end
      bwcg_pkg::BWCG_DONE: begin
        q_nxt.done = 1'b1;
        q_nxt.state = bwcg_pkg::BWCG_IDLE;
      end
    endcase
    // the offered cycle is built from the next state and then registered
    q_nxt.cyc_valid = 1'b0;
    q_nxt.cyc = '0;
    unique case (q_nxt.state)
      bwcg_pkg::BWCG_LOAD: begin
        q_nxt.cyc_valid = 1'b1;
        q_nxt.cyc.load_colour_cycle = !q_nxt.is_sgram;
        q_nxt.cyc.special_register_set_cycle = q_nxt.is_sgram;
        q_nxt.cyc.addr = q_nxt.addr;
        q_nxt.cyc.data = q_nxt.colour;
        q_nxt.cyc.byte_en = 8'hFF;
      end
      bwcg_pkg::BWCG_WRITE: begin
        q_nxt.cyc_valid = 1'b1;
        q_nxt.cyc.addr = q_nxt.addr;
        if (q_nxt.bw_type == `BWCG_BW_SIM) begin
          q_nxt.cyc.masked_write = 1'b1;
          q_nxt.cyc.addr = {q_nxt.addr[31:3], 3'h0};
          q_nxt.cyc.data = q_nxt.colour;
          q_nxt.cyc.byte_en = q_nxt.mask[7:0];
        end else begin
          q_nxt.cyc.block_write_cycle = 1'b1;
          q_nxt.cyc.byte_en = 8'hFF;
        end
      end
      default: begin
        q_nxt.cyc_valid = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; data bus pattern chosen from the registered mask
  logic [63:0] bus_data;
  always_comb begin
    bus_data = q_r.cyc.data;
    if (q_r.cyc.block_write_cycle) begin
      unique case ({q_r.bw_type == `BWCG_BW_8X, q_r.big_endian})
        2'h3: bus_data = map8_be;
        2'h2: bus_data = map8_le;
        2'h1: bus_data = map4_be;
        default: bus_data = map4_le;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign CYCLE_VALID = q_r.cyc_valid;
  always_comb begin
    CYCLE = q_r.cyc;
    CYCLE.data = bus_data;
  end
  assign BUSY = (q_r.state != bwcg_pkg::BWCG_IDLE);
  assign DONE = q_r.done;
  assign XFER_ERROR = q_r.err;

endmodule // bwcg_core
`default_nettype wire

// file: logic/bwcg_defs.svh
// constants for the block-write cycle generator
// assumes inclusion by bare name from the package and the design file
`ifndef BWCG_DEFS_SVH
`define BWCG_DEFS_SVH
`define BWCG_BW_SIM 2'h0
`define BWCG_BW_RSV 2'h1
`define BWCG_BW_4X 2'h2
`define BWCG_BW_8X 2'h3
`define BWCG_PAM_BLOCK_WRITE 3'h2
`define BWCG_ALIGN_64_BITS 6
`define BWCG_ALIGN_32_BITS 5
`define BWCG_STEP_8X 7'h40
`define BWCG_STEP_4X 7'h20
`define BWCG_STEP_SIM 7'h08
`define BWCG_ONCHIP_TOP 32'h01FFFFFF
`endif

// file: logic/bwcg_pkg.sv
// types shared by the block-write cycle generator
// assumes bwcg_defs.svh is on the include path
`include "bwcg_defs.svh"
package bwcg_pkg;
  typedef enum logic [1:0] {
    BWCG_IDLE,
    BWCG_LOAD,
    BWCG_WRITE,
    BWCG_DONE
  } bwcg_state_t;

  typedef struct packed {
    logic [2:0] access_mode_select;
    logic long_form;
    logic [1:0] block_write_type;
    logic big_endian;
    logic [31:0] dst_addr;
    logic [63:0] colour;
    logic [15:0] mask_bits;
  } bwcg_param_t;

  typedef struct packed {
    logic load_colour_cycle;
    logic special_register_set_cycle;
    logic block_write_cycle;
    logic masked_write;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0] byte_en;
  } bwcg_cycle_t;

  typedef struct packed {
    bwcg_state_t state;
    logic [1:0] bw_type;
    logic big_endian;
    logic is_sgram;
    logic [31:0] addr;
    logic [63:0] colour;
    logic [127:0] mask;
    logic [7:0] mask_left;
    logic [5:0] skip;
    logic err;
    logic done;
    bwcg_cycle_t cyc;
    logic cyc_valid;
  } bwcg_regs_t;
endpackage : bwcg_pkg

// file: tb/bwcg_core_chk.sv
// port checker for the block-write cycle generator
// assumes a bind onto bwcg_core and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bwcg_defs.svh"
module bwcg_core_chk (
  input wire logic REF_CLK, // clock
  input wire logic RST_N, // reset
  input wire logic START, // start
  input wire logic RESUME, // resume
  input wire logic SUSPEND, // suspend
  input wire logic BANK_SGRAM, // sgram bank
  input wire bwcg_pkg::bwcg_param_t PARAM, // parameters
  input wire logic CYCLE_READY, // taken
  input wire logic CYCLE_VALID, // offered
  input wire bwcg_pkg::bwcg_cycle_t CYCLE, // cycle
  input wire logic BUSY, // busy
  input wire logic DONE, // done
  input wire logic XFER_ERROR // refused
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [1:0] ty_r;
  logic [63:0] col_r;
  logic [15:0] mask_r;
  logic [31:0] dst_r;
  logic take;
  logic ok;
  logic ld;
  assign take = START && !BUSY;
  assign ld = CYCLE.load_colour_cycle || CYCLE.special_register_set_cycle;
  assign ok = PARAM.access_mode_select == `BWCG_PAM_BLOCK_WRITE && PARAM.long_form &&
    PARAM.block_write_type != `BWCG_BW_RSV && PARAM.dst_addr > `BWCG_ONCHIP_TOP &&
    PARAM.dst_addr[5:0] == 6'h00;
  // parameters of the transfer last taken
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ty_r <= 2'h0;
      col_r <= 64'h0;
      mask_r <= 16'h0;
      dst_r <= 32'h0;
    end else if (take) begin
      ty_r <= PARAM.block_write_type;
      col_r <= PARAM.colour;
      mask_r <= PARAM.mask_bits;
      dst_r <= PARAM.dst_addr;
    end
  end
  ////////////////////////////////
  sequence s_load_taken;
    CYCLE_VALID && CYCLE_READY && ld;
  endsequence
  sequence s_write_offered;
    CYCLE_VALID && CYCLE.block_write_cycle && CYCLE.addr[4:0] == 5'h00;
  endsequence
  a_bad_start: assert property (take && !ok |=> XFER_ERROR && !CYCLE_VALID)
    else $error("bad start not refused");
  a_load_first: assert property (take && ok && PARAM.block_write_type[1] |=> CYCLE_VALID && ld)
    else $error("no colour load at start");
  a_load_kind: assert property (CYCLE_VALID && ld |-> CYCLE.data == col_r &&
    CYCLE.load_colour_cycle == !BANK_SGRAM && CYCLE.special_register_set_cycle == BANK_SGRAM)
    else $error("colour load wrong");
  a_write_follows: assert property (s_load_taken |=> ##[0:4] s_write_offered)
    else $error("no block write after load");
  a_sim_masked: assert property (CYCLE_VALID && ty_r == `BWCG_BW_SIM |->
    CYCLE.masked_write && !ld && CYCLE.data == col_r)
    else $error("emulated cycle wrong");
  a_sim_first: assert property (take && ok && PARAM.block_write_type == `BWCG_BW_SIM |=>
    CYCLE_VALID && CYCLE.byte_en == mask_r[7:0] && CYCLE.addr == dst_r)
    else $error("first emulated write wrong");
  a_bw_ones: assert property (CYCLE_VALID && CYCLE.block_write_cycle |->
    $countones(CYCLE.data) == (ty_r[0] ? 1 : 2) * $countones(mask_r))
    else $error("mask line count wrong");
  a_resume_load: assert property (RESUME && !BUSY && ty_r[1] |=> CYCLE_VALID && ld)
    else $error("no colour load on resume");
endmodule // bwcg_core_chk
`default_nettype wire

// file: tb/bwcg_mem_model.sv
// memory sequencer stand-in: takes offered cycles and logs them
// assumes stall may hold ready low for any span
`timescale 1ns/1ps
`default_nettype none
module bwcg_mem_model (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic stall, // hold off acceptance
  input wire logic valid, // cycle offered
  input wire bwcg_pkg::bwcg_cycle_t cyc, // offered cycle
  output logic ready // cycle taken
);
  bwcg_pkg::bwcg_cycle_t log_q[$];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= !stall;
      if (valid && ready) begin
        log_q.push_back(cyc);
      end
    end
  end
endmodule // bwcg_mem_model
`default_nettype wire

// file: tb/bwcg_core_bench.sv
// self-checking bench for the block-write cycle generator
// assumes design, checker and memory stand-in compiled first
`timescale 1ns/1ps
`default_nettype none
`include "bwcg_defs.svh"
module bwcg_core_bench;
  localparam logic [63:0] COL = 64'h0123456789ABCDEF;
  localparam logic [15:0] MSK = 16'h8C31;
  localparam logic [31:0] DST = 32'h80001040;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic START = 1'b0;
  logic RESUME = 1'b0;
  logic SUSPEND = 1'b0;
  logic BANK_SGRAM = 1'b0;
  logic stall = 1'b0;
  bwcg_pkg::bwcg_param_t PARAM = '0;
  logic CYCLE_READY, CYCLE_VALID, BUSY, DONE, XFER_ERROR;
  bwcg_pkg::bwcg_cycle_t CYCLE;
  int fail_count = 0;
  int samples_checked = 0;
  bwcg_core bwcg_core_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .START(START), .RESUME(RESUME),
    .SUSPEND(SUSPEND), .BANK_SGRAM(BANK_SGRAM), .PARAM(PARAM), .CYCLE_READY(CYCLE_READY),
    .CYCLE_VALID(CYCLE_VALID), .CYCLE(CYCLE), .BUSY(BUSY), .DONE(DONE), .XFER_ERROR(XFER_ERROR));
  bwcg_mem_model bwcg_mem_model_i (.clk(REF_CLK), .rst_n(RST_N), .stall(stall),
    .valid(CYCLE_VALID), .cyc(CYCLE), .ready(CYCLE_READY));
  initial begin
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  ////////////////////////////////
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic bwcg_pkg::bwcg_cycle_t lg(input int i);
    return bwcg_mem_model_i.log_q[i];
  endfunction
  // expected bus lines for a mask, stride eight, pairs four apart
  function automatic logic [63:0] map(input logic [15:0] m, input logic be, input logic x4);
    logic [63:0] d;
    int a;
    d = '0;
    for (int g = 0; g < 16; g++) begin
      a = 8 * (g % 8) + g / 8;
      if (m[g]) begin
        d[be ? 63 - a : a] = 1'b1;
        if (x4) begin
          d[be ? 59 - a : a + 4] = 1'b1;
        end
      end
    end
    return d;
  endfunction
  task automatic start(input logic [2:0] md, input logic lf, input logic [1:0] ty,
      input logic be, input logic [31:0] dst, input logic sg);
    bwcg_mem_model_i.log_q.delete();
    @(posedge REF_CLK);
    BANK_SGRAM <= sg;
    PARAM <= '{md, lf, ty, be, dst, COL, MSK};
    START <= 1'b1;
    @(posedge REF_CLK);
    START <= 1'b0;
  endtask
  task automatic wait_end;
    int n;
    n = 0;
    while (DONE !== 1'b1 && XFER_ERROR !== 1'b1 && n < 100) begin
      @(negedge REF_CLK);
      n++;
    end
    check("finished", n < 100, 1'b1);
  endtask
  task automatic t_hw(input logic [1:0] ty, input logic be, input logic sg);
    start(3'h2, 1'b1, ty, be, DST, sg);
    wait_end();
    check("cycles", bwcg_mem_model_i.log_q.size(), 2);
    check("load", {lg(0).load_colour_cycle, lg(0).special_register_set_cycle, lg(0).data},
      {!sg, sg, COL});
    check("write", {lg(1).block_write_cycle, lg(1).addr}, {1'b1, DST});
    check("lines", lg(1).data, map(MSK, be, ty == `BWCG_BW_4X));
    $display("hardware block write type %0d endian %0d done", ty, be);
  endtask
  task automatic t_sim;
    start(3'h2, 1'b1, `BWCG_BW_SIM, 1'b0, DST, 1'b1);
    wait_end();
    check("sim cycles", bwcg_mem_model_i.log_q.size(), 2);
    for (int i = 0; i < 2; i++) begin
      check("sim", {lg(i).load_colour_cycle, lg(i).masked_write, lg(i).data}, {2'b01, COL});
      check("strobes", lg(i).byte_en, MSK[8*i+:8]);
      check("sim addr", lg(i).addr, DST + 32'(8 * i));
    end
    $display("emulated block write done");
  endtask
  task automatic t_err;
    for (int i = 0; i < 5; i++) begin
      start(i == 0 ? 3'h0 : 3'h2, i != 1, i == 2 ? `BWCG_BW_RSV : `BWCG_BW_8X, 1'b0,
        i == 3 ? 32'h01FFFFC0 : DST + (i == 4 ? 32'h20 : 32'h0), 1'b0);
      wait_end();
      check("refused", {XFER_ERROR, bwcg_mem_model_i.log_q.size() == 0}, 2'b11);
    end
    $display("refusals done");
  endtask
  task automatic t_resume;
    stall <= 1'b1;
    start(3'h2, 1'b1, `BWCG_BW_8X, 1'b0, DST, 1'b0);
    repeat (3) @(posedge REF_CLK);
    SUSPEND <= 1'b1;
    @(posedge REF_CLK);
    SUSPEND <= 1'b0;
    stall <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    check("suspended", BUSY, 1'b0);
    @(posedge REF_CLK);
    RESUME <= 1'b1;
    @(posedge REF_CLK);
    RESUME <= 1'b0;
    wait_end();
    check("reload", {lg(0).load_colour_cycle, lg(1).block_write_cycle}, 2'b11);
    check("resumed lines", lg(1).data, map(MSK, 1'b0, 1'b0));
    $display("suspend and resume done");
  endtask
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST_N <= 1'b1;
    t_hw(`BWCG_BW_8X, 1'b0, 1'b0);
    t_hw(`BWCG_BW_8X, 1'b1, 1'b1);
    t_hw(`BWCG_BW_4X, 1'b0, 1'b1);
    t_hw(`BWCG_BW_4X, 1'b1, 1'b0);
    t_sim();
    t_err();
    t_resume();
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule // bwcg_core_bench
bind bwcg_core bwcg_core_chk bwcg_core_chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .START(START),
  .RESUME(RESUME), .SUSPEND(SUSPEND), .BANK_SGRAM(BANK_SGRAM), .PARAM(PARAM),
  .CYCLE_READY(CYCLE_READY), .CYCLE_VALID(CYCLE_VALID), .CYCLE(CYCLE), .BUSY(BUSY),
  .DONE(DONE), .XFER_ERROR(XFER_ERROR));
`default_nettype wire
